// [include/pds_regs.vh]
// register map, field positions, reset values and timing constants of the phase directional block
`ifndef PDS_REGS_VH
`define PDS_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define PDS_ADDR_CTRL 8'h00
`define PDS_ADDR_ANGLE 8'h04
`define PDS_ADDR_POLTHR 8'h08
`define PDS_ADDR_STATUS 8'h0C
`define PDS_ADDR_ID 8'h10

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define PDS_CTRL_ENABLE 0
`define PDS_CTRL_BLOCK_EXP 1
`define PDS_CTRL_ACB 2
`define PDS_CTRL_TARGET_LO 3
`define PDS_CTRL_TARGET_HI 4
`define PDS_CTRL_SRC_LO 5
`define PDS_CTRL_SRC_HI 6
`define PDS_CTRL_W 7

////////////////////////////////////////////////////////////////////////////////
// status register fields, three bits each, phase a lowest
`define PDS_STAT_BLOCK_LO 0
`define PDS_STAT_VOK_LO 3
`define PDS_STAT_MEMV_LO 6
`define PDS_STAT_EXP_LO 9

////////////////////////////////////////////////////////////////////////////////
// reset values; magnitudes in per unit with 1.000 pu = 16'h1000
`define PDS_CTRL_RST 7'h00
`define PDS_ANGLE_RST 16'h0000
`define PDS_POLTHR_RST 16'h0B33
`define PDS_CUR_MIN 16'h00CD
// arbitrary neutral identification value
`define PDS_ID_VALUE 32'h00005D5D

////////////////////////////////////////////////////////////////////////////////
// angle encoding: full turn is 2**16, half turn below
`define PDS_ANGLE_HALF 16'h8000

////////////////////////////////////////////////////////////////////////////////
// axi responses
`define PDS_RESP_OKAY 2'h0
`define PDS_RESP_SLVERR 2'h2

////////////////////////////////////////////////////////////////////////////////
// voltage memory time
`define PDS_MEM_TIME_MS 24'd1000
`define PDS_CLK_KHZ 24'd10000

`endif

// [core/pds_phase.v]
// one directional element: polarizing reference, voltage memory, angle comparator
`timescale 1ns/1ps
`include "pds_regs.vh"

module pds_phase
#(
   parameter ANGW = 16,
   parameter MAGW = 16,
   parameter TMRW = 24,
   parameter [TMRW-1:0] MEM_CYCLES = 24'd10000000
)
(
   input wire clk,
   input wire reset_n,
   input wire enable,
   input wire block_on_memory_expiry,
   input wire acb_rotation,
   input wire [ANGW-1:0] characteristic_angle,
   input wire [MAGW-1:0] pol_threshold,
   input wire [MAGW-1:0] cur_mag,
   input wire [ANGW-1:0] cur_angle,
   input wire [MAGW-1:0] pol_mag,
   input wire [ANGW-1:0] pol_angle,
   output reg block_out,
   output wire voltage_ok,
   output reg memory_valid,
   output reg memory_expired
);

reg voltage_ok_d;
reg [ANGW-1:0] mem_angle;
reg [TMRW-1:0] mem_count;
reg next_block;
wire collapse;
wire cur_ok;
wire in_zone;
wire [ANGW-1:0] base_angle;
wire [ANGW-1:0] ref_angle;
wire [ANGW-1:0] diff;

assign voltage_ok = (pol_mag > pol_threshold);
assign collapse = voltage_ok_d & ~voltage_ok;
assign cur_ok = (cur_mag > `PDS_CUR_MIN);
assign base_angle = voltage_ok ? pol_angle : mem_angle;
// acb reverses the line voltage, i.e. adds a half turn
assign ref_angle = base_angle + (acb_rotation ? `PDS_ANGLE_HALF : {ANGW{1'b0}}) + characteristic_angle;
assign diff = cur_angle - ref_angle;
// top two bits equal means the difference lies in the -90..+90 half plane
assign in_zone = (diff[ANGW-1] == diff[ANGW-2]);

////////////////////////////////////////////////////////////////////////////////
// voltage memory and its validity timer
always @(posedge clk)
begin
   if (!reset_n)
   begin
      voltage_ok_d <= 1'b0;
      mem_angle <= {ANGW{1'b0}};
      mem_count <= {TMRW{1'b0}};
      memory_valid <= 1'b0;
      memory_expired <= 1'b1;
   end
   else
   begin
      voltage_ok_d <= voltage_ok;
      if (voltage_ok)
      begin
         mem_angle <= pol_angle;
         mem_count <= {TMRW{1'b0}};
         memory_valid <= 1'b0;
         memory_expired <= 1'b0;
      end
      else if (collapse)
      begin
         mem_count <= {TMRW{1'b0}};
         memory_valid <= 1'b1;
      end
      else if (memory_valid)
      begin
         if (mem_count == MEM_CYCLES - 1'b1)
         begin
            memory_valid <= 1'b0;
            memory_expired <= 1'b1;
         end
         else
         begin
            mem_count <= mem_count + 1'b1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// output decision
always @*
begin
   if (!enable || !cur_ok)
   begin
      next_block = 1'b0;
   end
   // the collapse cycle already runs on the stored angle, else one false expiry decision
   else if (voltage_ok || memory_valid || collapse)
   begin
      next_block = ~in_zone;
   end
   else
   begin
      next_block = block_on_memory_expiry;
   end
end

always @(posedge clk)
begin
   if (!reset_n)
   begin
      block_out <= 1'b0;
   end
   else
   begin
      block_out <= next_block;
   end
end

endmodule // pds_phase

// [core/pds_top.v]
// phase directional supervision: three elements behind an axi4-lite settings slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pds_regs.vh"

module pds_top
#(
   parameter NSRC = 4,
   parameter SRCW = 2,
   parameter ANGW = 16,
   parameter MAGW = 16,
   parameter TMRW = 24,
   parameter [TMRW-1:0] MEM_CYCLES = `PDS_MEM_TIME_MS * `PDS_CLK_KHZ
)
(
   input wire CORE_CLK,
   input wire RESET_N,
   input wire [NSRC*3*MAGW-1:0] PHASE_CURRENT_MAG,
   input wire [NSRC*3*ANGW-1:0] PHASE_CURRENT_ANGLE,
   input wire [NSRC*3*MAGW-1:0] LINE_VOLTAGE_MAG,
   input wire [NSRC*3*ANGW-1:0] LINE_VOLTAGE_ANGLE,
   output wire [2:0] DIRECTIONAL_BLOCK,
   input wire [7:0] S_AXI_AWADDR,
   input wire [2:0] S_AXI_AWPROT,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire [2:0] S_AXI_ARPROT,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
// settings registers

reg [`PDS_CTRL_W-1:0] ctrl;
reg [ANGW-1:0] characteristic_angle;
reg [MAGW-1:0] pol_threshold;

wire enable;
wire block_on_memory_expiry;
wire acb_rotation;
wire [SRCW-1:0] src_sel;
wire [2:0] block_vec;
wire [2:0] vok_vec;
wire [2:0] memv_vec;
wire [2:0] exp_vec;

assign enable = ctrl[`PDS_CTRL_ENABLE];
assign block_on_memory_expiry = ctrl[`PDS_CTRL_BLOCK_EXP];
assign acb_rotation = ctrl[`PDS_CTRL_ACB];
// the target field is stored and read back only; it steers nothing
assign src_sel = ctrl[`PDS_CTRL_SRC_HI:`PDS_CTRL_SRC_LO];

////////////////////////////////////////////////////////////////////////////////
// write channel state

reg aw_have;
reg w_have;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write;

assign S_AXI_AWREADY = ~aw_have & ~S_AXI_BVALID;
assign S_AXI_WREADY = ~w_have & ~S_AXI_BVALID;
assign do_write = aw_have & w_have;

function [31:0] pds_merge;
   input [31:0] old_value;
   input [31:0] new_value;
   input [3:0] strb;
   integer b;
   begin
      pds_merge = old_value;
      for (b = 0; b < 4; b = b + 1)
      begin
         if (strb[b])
         begin
            pds_merge[b*8 +: 8] = new_value[b*8 +: 8];
         end
      end
   end
endfunction

wire [31:0] ctrl_merged;
wire [31:0] angle_merged;
wire [31:0] thr_merged;
wire write_mapped;

assign ctrl_merged = pds_merge({{(32-`PDS_CTRL_W){1'b0}}, ctrl}, w_data, w_strb);
assign angle_merged = pds_merge({{(32-ANGW){1'b0}}, characteristic_angle}, w_data, w_strb);
assign thr_merged = pds_merge({{(32-MAGW){1'b0}}, pol_threshold}, w_data, w_strb);
assign write_mapped = (aw_addr == `PDS_ADDR_CTRL) || (aw_addr == `PDS_ADDR_ANGLE) ||
                      (aw_addr == `PDS_ADDR_POLTHR);

always @(posedge CORE_CLK)
begin
   if (!RESET_N)
   begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PDS_RESP_OKAY;
   end
   else
   begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_have <= 1'b1;
         aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_have <= 1'b1;
         w_data <= S_AXI_WDATA;
         w_strb <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= write_mapped ? `PDS_RESP_OKAY : `PDS_RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
         S_AXI_BVALID <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// settings update; writes to status or id are refused with slverr

always @(posedge CORE_CLK)
begin
   if (!RESET_N)
   begin
      ctrl <= `PDS_CTRL_RST;
      characteristic_angle <= `PDS_ANGLE_RST;
      pol_threshold <= `PDS_POLTHR_RST;
   end
   else if (do_write)
   begin
      case (aw_addr)
         `PDS_ADDR_CTRL:
         begin
            ctrl <= ctrl_merged[`PDS_CTRL_W-1:0];
         end
         `PDS_ADDR_ANGLE:
         begin
            characteristic_angle <= angle_merged[ANGW-1:0];
         end
         `PDS_ADDR_POLTHR:
         begin
            pol_threshold <= thr_merged[MAGW-1:0];
         end
         default:
         begin
            ctrl <= ctrl;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// read channel

reg [31:0] next_rdata;
reg [1:0] next_rresp;
wire [31:0] status_word;

assign S_AXI_ARREADY = ~S_AXI_RVALID;
assign status_word = {20'h00000, exp_vec, memv_vec, vok_vec, block_vec};

always @*
begin
   next_rresp = `PDS_RESP_OKAY;
   case (S_AXI_ARADDR)
      `PDS_ADDR_CTRL:
      begin
         next_rdata = {{(32-`PDS_CTRL_W){1'b0}}, ctrl};
      end
      `PDS_ADDR_ANGLE:
      begin
         next_rdata = {{(32-ANGW){1'b0}}, characteristic_angle};
      end
      `PDS_ADDR_POLTHR:
      begin
         next_rdata = {{(32-MAGW){1'b0}}, pol_threshold};
      end
      `PDS_ADDR_STATUS:
      begin
         next_rdata = status_word;
      end
      `PDS_ADDR_ID:
      begin
         next_rdata = `PDS_ID_VALUE;
      end
      default:
      begin
         next_rdata = 32'h00000000;
         next_rresp = `PDS_RESP_SLVERR;
      end
   endcase
end

always @(posedge CORE_CLK)
begin
   if (!RESET_N)
   begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `PDS_RESP_OKAY;
   end
   else if (S_AXI_ARVALID && S_AXI_ARREADY)
   begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
   end
   else if (S_AXI_RVALID && S_AXI_RREADY)
   begin
      S_AXI_RVALID <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// three phase elements
// line voltages are packed ab, bc, ca; phase i is polarized by entry (i+1) mod 3,
// so a sees bc, b sees ca, c sees ab for abc rotation

genvar i;
generate
   for (i = 0; i < 3; i = i + 1)
   begin : g_phase
      localparam VIDX = (i + 1) % 3;
      wire [MAGW-1:0] cur_mag;
      wire [ANGW-1:0] cur_angle;
      wire [MAGW-1:0] pol_mag;
      wire [ANGW-1:0] pol_angle;

      // source mux; one cycle of select change may mix channels for one decision
      assign cur_mag = PHASE_CURRENT_MAG[(src_sel * 3 + i) * MAGW +: MAGW];
      assign cur_angle = PHASE_CURRENT_ANGLE[(src_sel * 3 + i) * ANGW +: ANGW];
      assign pol_mag = LINE_VOLTAGE_MAG[(src_sel * 3 + VIDX) * MAGW +: MAGW];
      assign pol_angle = LINE_VOLTAGE_ANGLE[(src_sel * 3 + VIDX) * ANGW +: ANGW];

      pds_phase
      #(
         .ANGW(ANGW),
         .MAGW(MAGW),
         .TMRW(TMRW),
         .MEM_CYCLES(MEM_CYCLES)
      )
      u_phase
      (
         .clk(CORE_CLK),
         .reset_n(RESET_N),
         .enable(enable),
         .block_on_memory_expiry(block_on_memory_expiry),
         .acb_rotation(acb_rotation),
         .characteristic_angle(characteristic_angle),
         .pol_threshold(pol_threshold),
         .cur_mag(cur_mag),
         .cur_angle(cur_angle),
         .pol_mag(pol_mag),
         .pol_angle(pol_angle),
         .block_out(block_vec[i]),
         .voltage_ok(vok_vec[i]),
         .memory_valid(memv_vec[i]),
         .memory_expired(exp_vec[i])
      );
   end
endgenerate

// one independent block line per phase
assign DIRECTIONAL_BLOCK = block_vec;

endmodule // pds_top

// [dv/pds_chk_sva.sv]
// assertion checker for the phase directional top
`timescale 1ns/1ps
`include "pds_regs.vh"
module pds_chk
#(
   parameter NSRC = 4,
   parameter MAGW = 16
)
(
   input wire CORE_CLK,
   input wire RESET_N,
   input wire [NSRC*3*MAGW-1:0] PHASE_CURRENT_MAG,
   input wire [2:0] DIRECTIONAL_BLOCK,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   logic [2:0] low_cur;
   default clocking dc @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////
   // low on every source, so low whatever source is picked
   always_comb
   begin
      low_cur = 3'b111;
      for (int i = 0; i < NSRC*3; i++)
         if (PHASE_CURRENT_MAG[i*MAGW +: MAGW] > `PDS_CUR_MIN)
            low_cur[i%3] = 1'b0;
   end
   property p_rst; $rose(RESET_N) |-> DIRECTIONAL_BLOCK == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("block set after reset");
   property p_low; |low_cur |=> (DIRECTIONAL_BLOCK & $past(low_cur)) == 3'h0; endproperty
   a_low: assert property (p_low) else $error("block with low current");
   property p_wr; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_bh; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
   a_bh: assert property (p_bh) else $error("write answer repeated");
   property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_rh; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
   a_rh: assert property (p_rh) else $error("read answer repeated");
   property p_ab; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
   a_ab: assert property (p_ab) else $error("read taken while busy");
   property p_wb; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
   a_wb: assert property (p_wb) else $error("write taken while busy");
   c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
   c_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
   c_blk: cover property ($rose(DIRECTIONAL_BLOCK[0]));
endmodule // pds_chk

bind pds_top pds_chk #(.NSRC(NSRC), .MAGW(MAGW)) u_chk
(
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PHASE_CURRENT_MAG(PHASE_CURRENT_MAG),
   .DIRECTIONAL_BLOCK(DIRECTIONAL_BLOCK), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY)
);

// [dv/pds_front_model.sv]
// phasor front end and supervised overcurrent elements around the block
`timescale 1ns/1ps
module pds_front
#(
   parameter NSRC = 4,
   parameter SRC = 2,
   parameter DLY = 4
)
(
   input wire clk,
   input wire [2:0] blk,
   output logic [NSRC*48-1:0] cur_mag,
   output logic [NSRC*48-1:0] cur_ang,
   output logic [NSRC*48-1:0] volt_mag,
   output logic [NSRC*48-1:0] volt_ang,
   output logic [2:0] trip
);
   logic [7:0] cnt [3];
   // one source, three phases; voltage angles of entries ab, bc, ca
   task set(input int s, input logic [15:0] cm, ca, vm, v0, v1, v2);
      for (int p = 0; p < 3; p++)
      begin
         cur_mag[(s*3+p)*16 +: 16] <= cm;
         cur_ang[(s*3+p)*16 +: 16] <= ca;
         volt_mag[(s*3+p)*16 +: 16] <= vm;
      end
      volt_ang[s*48 +: 48] <= {v2, v1, v0};
   endtask
   ////////////////////////////////////////
   // a one on the block input holds the element off; delay covers the block setup time
   always @(posedge clk)
      for (int p = 0; p < 3; p++)
         if (blk[p] || cur_mag[(SRC*3+p)*16 +: 16] < 16'h0800)
            cnt[p] <= 8'h00;
         else if (cnt[p] < DLY)
            cnt[p] <= cnt[p] + 8'h01;
   assign trip = {cnt[2] == DLY, cnt[1] == DLY, cnt[0] == DLY};
endmodule // pds_front

// [dv/phase_directional_supervision_tb.sv]
// self-checking bench for the phase directional supervision block
`timescale 1ns/1ps
`include "pds_regs.vh"
module phase_directional_supervision_tb;
   localparam [23:0] MEM = 24'd20;
   localparam [1:0] OK = `PDS_RESP_OKAY;
   localparam [7:0] CTL = `PDS_ADDR_CTRL;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [2:0] prot;
   logic [15:0] vang [3];
   logic [2:0] e;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [2:0] blk, trip;
   wire [191:0] cm, ca, vm, va;
   int err_total, check_count;
   pds_front #(.NSRC(4), .SRC(2), .DLY(4)) fe
   (
      .clk(clk), .blk(blk), .cur_mag(cm), .cur_ang(ca), .volt_mag(vm), .volt_ang(va), .trip(trip)
   );
   // memory time cut from one second to keep the run short
   pds_top #(.NSRC(4), .MEM_CYCLES(MEM)) DUT
   (
      .CORE_CLK(clk), .RESET_N(rst_n), .PHASE_CURRENT_MAG(cm), .PHASE_CURRENT_ANGLE(ca),
      .LINE_VOLTAGE_MAG(vm), .LINE_VOLTAGE_ANGLE(va), .DIRECTIONAL_BLOCK(blk),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(prot), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(prot), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////
   task chk(input string n, input logic [31:0] x, g);
      check_count++;
      if (g !== x)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ready is looked at mid-cycle, where it is settled for the coming edge
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      aw = 0;
      w = 0;
      b = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b)
      begin
         @(negedge clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         if (b) chk("bresp", r, bresp);
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic t, v;
      t = 0;
      v = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!v)
      begin
         @(negedge clk);
         t = arvalid & arready;
         v = rvalid;
         if (v) chk("rdata", d, rdata);
         if (v) chk("rresp", r, rresp);
         @(posedge clk);
         if (t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task drv(input logic [15:0] c, v);
      fe.set(2, c, 16'h0000, v, vang[0], vang[1], vang[2]);
   endtask
   task chkb(input logic [2:0] x);
      repeat (3) @(posedge clk);
      chk("block", x, blk);
   endtask
   // phase a uses entry bc, b uses ca, c uses ab; current angle is zero
   function automatic logic [2:0] expb(input logic acb, input logic [15:0] ang);
      logic [15:0] d;
      for (int p = 0; p < 3; p++)
      begin
         d = 16'h0000 - vang[(p+1)%3] - {acb, 15'h0000} - ang;
         // block outside the -90..+90 half plane; +90 itself is outside
         expb[p] = (d >= 16'h4000) && (d < 16'hC000);
      end
   endfunction
   ////////////////////////////////////////
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      stop_test;
   end
   initial
   begin
      err_total = 0;
      check_count = 0;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      prot = 3'h2;
      vang = '{16'h0000, 16'h4000, 16'h8000};
      for (int s = 0; s < 4; s++)
         fe.set(s, 16'h1000, 16'h8000, (s % 2) ? 16'h1000 : 16'h0000, 16'h2000, 16'h2000, 16'h2000);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      axr(CTL, 32'h0, OK);
      axr(`PDS_ADDR_ANGLE, 32'h0, OK);
      axr(`PDS_ADDR_POLTHR, 32'h0B33, OK);
      axr(`PDS_ADDR_STATUS, 32'h0E00, OK);
      axr(`PDS_ADDR_ID, `PDS_ID_VALUE, OK);
      axr(8'h14, 32'h0, `PDS_RESP_SLVERR);
      axw(`PDS_ADDR_ID, 32'h1, `PDS_RESP_SLVERR);
      wstrb <= 4'h1;
      axw(`PDS_ADDR_POLTHR, 32'h000012FF, OK);
      axr(`PDS_ADDR_POLTHR, 32'h00000BFF, OK);
      wstrb <= 4'hF;
      axw(`PDS_ADDR_POLTHR, 32'h00000B33, OK);
      chk("block", 3'h0, blk);
      $display("test reset done");
      drv(16'h1000, 16'h1000);
      for (int i = 0; i < 4; i++)
      begin
         axw(`PDS_ADDR_ANGLE, i[0] ? 32'h4000 : 32'h0, OK);
         axw(CTL, {25'h0, 2'b10, (i == 3) ? 2'b11 : 2'b00, i[1], 2'b01}, OK);
         chkb(expb(i[1], i[0] ? 16'h4000 : 16'h0));
      end
      $display("test direction done");
      axw(`PDS_ADDR_ANGLE, 32'h0, OK);
      axw(CTL, 32'h41, OK);
      // every source low, so the checker sees the low-current case too
      for (int s = 0; s < 4; s++)
         fe.set(s, 16'h00CD, 16'h0000, 16'h1000, vang[0], vang[1], vang[2]);
      chkb(3'h0);
      drv(16'h00CE, 16'h1000);
      chkb(expb(1'b0, 16'h0));
      axw(CTL, 32'h40, OK);
      chkb(3'h0);
      $display("test current done");
      axw(CTL, 32'h43, OK);
      e = expb(1'b0, 16'h0);
      vang = '{16'h8000, 16'hC000, 16'h0000};
      drv(16'h1000, 16'h0B33);
      @(posedge clk);
      @(negedge clk);
      chk("block", e, blk);
      repeat (5) @(posedge clk);
      chk("block", e, blk);
      repeat (MEM + 2) @(posedge clk);
      chk("block", 3'h7, blk);
      drv(16'h1000, 16'h0B34);
      chkb(expb(1'b0, 16'h0));
      axw(CTL, 32'h41, OK);
      e = expb(1'b0, 16'h0);
      drv(16'h1000, 16'h0000);
      repeat (10) @(posedge clk);
      drv(16'h1000, 16'h1000);
      repeat (3) @(posedge clk);
      drv(16'h1000, 16'h0000);
      repeat (15) @(posedge clk);
      chk("block", e, blk);
      repeat (MEM) @(posedge clk);
      chk("block", 3'h0, blk);
      chk("trip", 3'h7, trip);
      drv(16'h1000, 16'h1000);
      chkb(e);
      $display("test memory done");
      stop_test;
   end
endmodule // phase_directional_supervision_tb
